// ===== rtl/tip_consts.svh
// constants for the trigger and inhibit pin block
`ifndef TIP_CONSTS_SVH
`define TIP_CONSTS_SVH
`define TIP_CLK_MHZ         200
`define TIP_MIN_LOW_US      30
`define TIP_MIN_LOW_CYC     ((`TIP_MIN_LOW_US) * (`TIP_CLK_MHZ))
`define TIP_CNT_W           16
`define TIP_ADR_CTRL        8'h00
`define TIP_ADR_STATUS      8'h04
`define TIP_ADR_MASK        8'h08
`define TIP_ADR_PWM_PER     8'h0c
`define TIP_ADR_PWM_HIGH    8'h10
`define TIP_ADR_STATE       8'h14
`define TIP_CTRL_RST        32'h0000_0000
`define TIP_PWM_PER_RST     32'h0000_c350
`define TIP_PWM_HIGH_RST    32'h0000_61a8
`define TIP_C_TRIG_OUT      0
`define TIP_C_TRIG_INV      1
`define TIP_C_SRC_EXT       2
`define TIP_C_INH_OUT       3
`define TIP_C_INH_LATCH     4
`define TIP_C_INH_INV       5
`define TIP_C_INH_DRV_LO    6
`define TIP_C_INH_DRV_HI    7
`define TIP_C_OUT_ON        8
`define TIP_C_PROT_CLR      9
`define TIP_S_TRIG_OUT      0
`define TIP_S_TRIG_IN       1
`define TIP_S_LATCH         2
`define TIP_S_LEVEL         3
`endif

// ===== rtl/tip_pkg.sv
// types for the trigger and inhibit pin block
package tip_pkg;
   typedef enum logic [1:0] {
      TIP_DRV_CONST0 = 2'b00,
      TIP_DRV_CONST1 = 2'b01,
      TIP_DRV_PWM    = 2'b10
   } tip_drv_t;
   typedef enum logic [1:0] {
      TIP_PIN_IDLE  = 2'b00,
      TIP_PIN_COUNT = 2'b01,
      TIP_PIN_WAIT  = 2'b10
   } tip_det_t;
endpackage

// ===== rtl/tip_io_pins.sv
// trigger pin and inhibit pin control logic with wishbone registers
//
// What this block does
// - trigger output pulses low on each run trigger
// - external valid input pulse starts loaded sequence
// - pulses hold low at least 30 us
// - inhibit offers level and latch modes
// - level mode idle high leaves output
// - level active forces output zero, shows inhibit only while output is on
// - level release restores output automatically
// - inverted polarity makes high the active level
// - latch mode idle pin changes nothing
// - latch pulse while output is on turns it off, flags protection
// - inhibit output logic one drives low level
// - inhibit output drives one, zero or pwm
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`include "tip_consts.svh"

module tip_io_pins #(
   parameter int unsigned MIN_LOW_CYC = `TIP_MIN_LOW_CYC
) (
   input  wire logic        clk_i,         // 200 mhz clock
   input  wire logic        rst_i,         // synchronous reset, high
   input  wire logic        wb_cyc_i,      // wishbone cycle
   input  wire logic        wb_stb_i,      // wishbone strobe
   input  wire logic        wb_we_i,       // wishbone write
   input  wire logic [7:0]  wb_adr_i,      // byte address
   input  wire logic [3:0]  wb_sel_i,      // byte enables
   input  wire logic [31:0] wb_dat_i,      // write data
   output logic      [31:0] wb_dat_o,      // read data
   output logic             wb_ack_o,      // acknowledge
   input  wire logic        run_trig_i,    // one-cycle: instrument fired run trigger
   output logic             seq_start_o,   // one-cycle: start loaded sequence
   input  wire logic        trig_pin_i,    // trigger pin level
   output logic             trig_pin_o,    // trigger pin drive value
   output logic             trig_pin_oe_o, // trigger pin drive enable
   input  wire logic        inh_pin_i,     // inhibit pin level
   output logic             inh_pin_o,     // inhibit pin drive value
   output logic             inh_pin_oe_o,  // inhibit pin drive enable
   output logic             out_enable_o,  // actual output allowed
   output logic             out_on_o,      // on indication
   output logic             inhibit_indication_o,         // level inhibit shown
   output logic             latched_inhibit_indication_o, // protection shown
   output logic             irq_o          // interrupt level
);
   import tip_pkg::*;

   localparam int unsigned CW = `TIP_CNT_W;

   logic [31:0] ctrl;
   logic [3:0]  irq_stat;
   logic [3:0]  irq_mask;
   logic [31:0] pwm_per;
   logic [31:0] pwm_high;
   logic        out_on;
   logic        prot;
   logic        bus_req;
   logic        trig_s1, trig_s2, inh_s1, inh_s2;
   logic        trig_valid, inh_valid;
   logic        ev_trig_out, ev_latch;
   logic        trig_act, inh_act;
   logic [CW-1:0] tout_cnt;
   logic [31:0] pwm_cnt;
   logic        inh_logic;
   tip_drv_t    inh_drv;
   logic        level_inhibit_mode;

   function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after the request, writes land on the edge that ends the ack cycle
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire   wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire   rd_stat = bus_req && !wb_we_i && (wb_adr_i == `TIP_ADR_STATUS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (bus_req && !wb_we_i) begin
         unique case (wb_adr_i)
            `TIP_ADR_CTRL:     wb_dat_o <= ctrl;
            `TIP_ADR_STATUS:   wb_dat_o <= {28'h0, irq_stat};
            `TIP_ADR_MASK:     wb_dat_o <= {28'h0, irq_mask};
            `TIP_ADR_PWM_PER:  wb_dat_o <= pwm_per;
            `TIP_ADR_PWM_HIGH: wb_dat_o <= pwm_high;
            `TIP_ADR_STATE:    wb_dat_o <= {28'h0, inh_act, trig_act, prot, out_on};
            default:           wb_dat_o <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl     <= `TIP_CTRL_RST;
         irq_mask <= 4'h0;
         pwm_per  <= `TIP_PWM_PER_RST;
         pwm_high <= `TIP_PWM_HIGH_RST;
      end else if (wr_en) begin
         unique case (wb_adr_i)
            `TIP_ADR_CTRL:     ctrl     <= merge_sel(ctrl, wb_dat_i, wb_sel_i);
            `TIP_ADR_MASK:     irq_mask <= wb_sel_i[0] ? wb_dat_i[3:0] : irq_mask;
            `TIP_ADR_PWM_PER:  pwm_per  <= merge_sel(pwm_per, wb_dat_i, wb_sel_i);
            `TIP_ADR_PWM_HIGH: pwm_high <= merge_sel(pwm_high, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // sticky events; a new event in the reading cycle survives the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= 4'h0;
      end else begin
         irq_stat <= (rd_stat ? 4'h0 : irq_stat)
                   | {level_inhibit_mode && inh_act, ev_latch, trig_valid, ev_trig_out};
      end
   end
   assign irq_o = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and pulse qualifiers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_s1 <= 1'b1;
         trig_s2 <= 1'b1;
         inh_s1  <= 1'b1;
         inh_s2  <= 1'b1;
      end else begin
         trig_s1 <= trig_pin_i;
         trig_s2 <= trig_s1;
         inh_s1  <= inh_pin_i;
         inh_s2  <= inh_s1;
      end
   end

   // active level: low normally, high when inverted
   assign trig_act = trig_s2 ^ ~ctrl[`TIP_C_TRIG_INV];
   assign inh_act  = inh_s2 ^ ~ctrl[`TIP_C_INH_INV];

   // one qualifier per input; a pulse counts once its active level lasts the width
   logic [CW-1:0] tq_cnt, iq_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !trig_act || ctrl[`TIP_C_TRIG_OUT]) begin
         tq_cnt <= '0;
      end else if (tq_cnt != CW'(MIN_LOW_CYC)) begin
         tq_cnt <= tq_cnt + 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || !inh_act || ctrl[`TIP_C_INH_OUT]) begin
         iq_cnt <= '0;
      end else if (iq_cnt != CW'(MIN_LOW_CYC)) begin
         iq_cnt <= iq_cnt + 1'b1;
      end
   end
   assign trig_valid = (tq_cnt == CW'(MIN_LOW_CYC - 1)) && trig_act && !ctrl[`TIP_C_TRIG_OUT];
   assign inh_valid  = (iq_cnt == CW'(MIN_LOW_CYC - 1)) && inh_act && !ctrl[`TIP_C_INH_OUT];

   // sequence starts only when the trigger source is external
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_start_o <= 1'b0;
      end else begin
         seq_start_o <= trig_valid && ctrl[`TIP_C_SRC_EXT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger output pulse; a trigger during a pulse restarts it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tout_cnt <= '0;
      end else if (ev_trig_out) begin
         tout_cnt <= CW'(MIN_LOW_CYC);
      end else if (tout_cnt != '0) begin
         tout_cnt <= tout_cnt - 1'b1;
      end
   end
   assign ev_trig_out = run_trig_i && ctrl[`TIP_C_TRIG_OUT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_pin_o    <= 1'b1;
         trig_pin_oe_o <= 1'b0;
      end else begin
         trig_pin_oe_o <= ctrl[`TIP_C_TRIG_OUT];
         trig_pin_o    <= (tout_cnt != '0) ? ctrl[`TIP_C_TRIG_INV]
                                           : ~ctrl[`TIP_C_TRIG_INV];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // inhibit input: level mode or latch mode
   assign level_inhibit_mode = !ctrl[`TIP_C_INH_LATCH];
   assign ev_latch = inh_valid && !level_inhibit_mode && out_on;

   // on state follows software; latch event clears it and it stays off until
   // protection is cleared and software turns it on again
   logic out_on_req_d;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_on       <= 1'b0;
         out_on_req_d <= 1'b0;
         prot         <= 1'b0;
      end else begin
         out_on_req_d <= ctrl[`TIP_C_OUT_ON];
         if (ev_latch) begin
            out_on <= 1'b0;
            prot   <= 1'b1;
         end else begin
            if (ctrl[`TIP_C_PROT_CLR]) begin
               prot <= 1'b0;
            end
            if (!ctrl[`TIP_C_OUT_ON]) begin
               out_on <= 1'b0;
            end else if (!out_on_req_d && !prot) begin
               out_on <= 1'b1;   // needs a fresh rising request
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_on_o                     <= 1'b0;
         out_enable_o                 <= 1'b0;
         inhibit_indication_o         <= 1'b0;
         latched_inhibit_indication_o <= 1'b0;
      end else begin
         out_on_o <= out_on;
         // idle level in level mode, or any level in latch mode, keeps output
         out_enable_o <= out_on && !(level_inhibit_mode && inh_act
                                     && !ctrl[`TIP_C_INH_OUT]);
         inhibit_indication_o <= out_on && level_inhibit_mode && inh_act
                                 && !ctrl[`TIP_C_INH_OUT];
         latched_inhibit_indication_o <= prot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // inhibit pin as output: constant or pwm, logic one drives low
   assign inh_drv = ctrl[`TIP_C_INH_DRV_HI] ? TIP_DRV_PWM
                  : (ctrl[`TIP_C_INH_DRV_LO] ? TIP_DRV_CONST1 : TIP_DRV_CONST0);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_cnt <= 32'h0;
      end else if (pwm_cnt + 32'h1 >= pwm_per) begin
         pwm_cnt <= 32'h0;
      end else begin
         pwm_cnt <= pwm_cnt + 32'h1;
      end
   end

   always_comb begin
      unique case (inh_drv)
         TIP_DRV_CONST0: inh_logic = 1'b0;
         TIP_DRV_CONST1: inh_logic = 1'b1;
         TIP_DRV_PWM:    inh_logic = (pwm_cnt < pwm_high);
         default:        inh_logic = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inh_pin_o    <= 1'b1;
         inh_pin_oe_o <= 1'b0;
      end else begin
         inh_pin_oe_o <= ctrl[`TIP_C_INH_OUT];
         inh_pin_o    <= ~inh_logic ^ ctrl[`TIP_C_INH_INV];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   int unsigned low_run;
   always_ff @(posedge clk_i) begin
      if (rst_i || trig_pin_o != ctrl[`TIP_C_TRIG_INV]) begin
         low_run <= 0;
      end else begin
         low_run <= low_run + 1;
      end
   end

   trig_pulse_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ev_trig_out |-> ##2 trig_pin_o == ctrl[`TIP_C_TRIG_INV])
      else $error("trigger pulse not started");
   trig_pulse_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(trig_pin_o != ctrl[`TIP_C_TRIG_INV]) && $stable(ctrl)
      |-> low_run >= MIN_LOW_CYC)
      else $error("trigger pulse too short");
   seq_start_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_start_o |-> $past(trig_valid) && $past(ctrl[`TIP_C_SRC_EXT]))
      else $error("sequence start without valid pulse");
   level_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
      inhibit_indication_o |-> !out_enable_o && out_on_o)
      else $error("level inhibit not forcing output off");
   level_restore_a: assert property (@(posedge clk_i) disable iff (rst_i)
      out_on && level_inhibit_mode && !inh_act && $stable(out_on) |=> out_enable_o)
      else $error("output not restored");
   latch_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ev_latch |=> !out_on ##1 latched_inhibit_indication_o && !out_on_o)
      else $error("latch pulse did not switch off");
   no_auto_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
      prot |=> !$rose(out_on))
      else $error("output re-enabled under protection");
   inh_drive_pol_a: assert property (@(posedge clk_i) disable iff (rst_i)
      inh_drv == TIP_DRV_CONST1 |=> inh_pin_o == $past(ctrl[`TIP_C_INH_INV]))
      else $error("inhibit output polarity wrong");
   pulse_qual_a: assert property (@(posedge clk_i) disable iff (rst_i)
      trig_valid |-> $past(trig_act, 2))
      else $error("trigger accepted without active level");

   ext_start_c:  cover property (@(posedge clk_i) disable iff (rst_i) seq_start_o);
   trig_out_c:   cover property (@(posedge clk_i) disable iff (rst_i) ev_trig_out);
   latch_hit_c:  cover property (@(posedge clk_i) disable iff (rst_i) ev_latch);
   level_hit_c:  cover property (@(posedge clk_i) disable iff (rst_i) inhibit_indication_o);
endmodule

// ===== verification/tip_far_end.sv
// far-side instrument model driving the trigger and inhibit pins
`timescale 1ns/100ps

module tip_far_end (
   input  wire logic clk_i,      // bench clock
   input  wire logic trig_o_i,   // device drive value, trigger pin
   input  wire logic trig_oe_i,  // device drive enable, trigger pin
   input  wire logic inh_o_i,    // device drive value, inhibit pin
   input  wire logic inh_oe_i,   // device drive enable, inhibit pin
   output logic      trig_pin_o, // resolved trigger pin level
   output logic      inh_pin_o   // resolved inhibit pin level
);
   logic trig_drv = 1'b1;
   logic inh_drv  = 1'b1;

   // a pin the device releases reads the far-end drive level, which idles high
   assign trig_pin_o = trig_oe_i ? trig_o_i : trig_drv;
   assign inh_pin_o  = inh_oe_i ? inh_o_i : inh_drv;

   // low pulse of n cycles; a proper source keeps it at least the minimum width
   task automatic pulse_trig(input int n);
      @(posedge clk_i) trig_drv <= 1'b0;
      repeat (n) @(posedge clk_i);
      trig_drv <= 1'b1;
   endtask

   task automatic pulse_inh(input int n);
      @(posedge clk_i) inh_drv <= 1'b0;
      repeat (n) @(posedge clk_i);
      inh_drv <= 1'b1;
   endtask

   task automatic set_inh(input logic v);
      @(posedge clk_i) inh_drv <= v;
   endtask
endmodule

// ===== verification/tip_io_pins_test.sv
// self-checking bench for the trigger and inhibit pin block
`timescale 1ns/100ps
`include "tip_consts.svh"
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected at %0t: %s", $time, m); end end

module tip_io_pins_test;
   localparam int MLC = 20;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run_trig = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat;
   logic        ack, seq, tpo, toe, ipo, ioe, oen, on, inhibit_indication, lat, irq, tpin, ipin;
   logic [31:0] exp_q[$];
   int          n_mismatch = 0, tests_run = 0, n_seq = 0, n, t;

   tip_io_pins #(.MIN_LOW_CYC(MLC)) dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .run_trig_i(run_trig), .seq_start_o(seq),
      .trig_pin_i(tpin), .trig_pin_o(tpo), .trig_pin_oe_o(toe), .inh_pin_i(ipin),
      .inh_pin_o(ipo), .inh_pin_oe_o(ioe), .out_enable_o(oen), .out_on_o(on),
      .inhibit_indication_o(inhibit_indication), .latched_inhibit_indication_o(lat), .irq_o(irq));
   tip_far_end far (.clk_i(clk), .trig_o_i(tpo), .trig_oe_i(toe), .inh_o_i(ipo),
      .inh_oe_i(ioe), .trig_pin_o(tpin), .inh_pin_o(ipin));

   initial begin
      forever #2.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read monitor: the oldest noted value is compared when ack appears
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0)
         `CHK(rdat, exp_q.pop_front(), "read data")
      if (seq === 1'b1)
         n_seq++;
   end

   // request held until ack is sampled high, then released for a cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      if (!w)
         exp_q.push_back(d);
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic done(input string s);
      repeat (4) @(posedge clk);
      $display("test %s finished", s);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hf75c));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wb(0, `TIP_ADR_CTRL, `TIP_CTRL_RST);
      wb(0, `TIP_ADR_PWM_PER, `TIP_PWM_PER_RST);
      wb(0, `TIP_ADR_PWM_HIGH, `TIP_PWM_HIGH_RST);
      wb(0, 8'h1c, 32'h0); // unmapped
      done("reset");
      // trigger output pulse, its width and the interrupt path
      wb(1, `TIP_ADR_MASK, 32'h0);
      wb(1, `TIP_ADR_CTRL, 32'h1);
      @(posedge clk) run_trig <= 1'b1;
      @(posedge clk) run_trig <= 1'b0;
      n = 0; t = 0;
      while (tpo !== 1'b0 && t < 10) begin @(posedge clk); t++; end
      while (tpo === 1'b0 && n < 200) begin @(posedge clk); n++; end
      `CHK(toe, 1'b1, "trigger pin not driven")
      `CHK(n >= MLC, 1'b1, "trigger pulse too short")
      `CHK(irq, 1'b0, "masked interrupt raised")
      wb(1, `TIP_ADR_MASK, 32'h1);
      `CHK(irq, 1'b1, "interrupt missing")
      wb(0, `TIP_ADR_STATUS, 32'h1);
      `CHK(irq, 1'b0, "interrupt not cleared")
      done("trigger out");
      // trigger input: a short pulse is ignored, a full one starts once
      wb(1, `TIP_ADR_CTRL, 32'h4);
      far.pulse_trig(MLC - 1);
      repeat (10) @(posedge clk);
      `CHK(n_seq, 0, "short pulse accepted")
      far.pulse_trig(MLC);
      repeat (10) @(posedge clk);
      `CHK(n_seq, 1, "sequence start count")
      done("trigger in");
      // level mode, normal then inverted polarity
      wb(1, `TIP_ADR_CTRL, 32'h100);
      repeat (4) @(posedge clk);
      `CHK(oen, 1'b1, "idle pin blocks output")
      far.set_inh(1'b0);
      repeat (6) @(posedge clk);
      `CHK({oen, on, inhibit_indication}, 3'b011, "level inhibit")
      far.set_inh(1'b1);
      repeat (6) @(posedge clk);
      `CHK({oen, on, inhibit_indication}, 3'b110, "level restore")
      wb(1, `TIP_ADR_CTRL, 32'h120);
      repeat (6) @(posedge clk);
      `CHK(oen, 1'b0, "inverted high not active")
      done("level");
      // latch mode: idle pin harmless, pulse latches off, software re-enables
      wb(1, `TIP_ADR_CTRL, 32'h110);
      repeat (6) @(posedge clk);
      `CHK({oen, on, lat}, 3'b110, "latch idle")
      far.pulse_inh(MLC + 10);
      repeat (10) @(posedge clk);
      `CHK({oen, on, lat}, 3'b001, "latch trip")
      wb(1, `TIP_ADR_CTRL, 32'h310);
      wb(1, `TIP_ADR_CTRL, 32'h110);
      `CHK({on, lat}, 2'b00, "output came back alone")
      wb(1, `TIP_ADR_CTRL, 32'h010);
      wb(1, `TIP_ADR_CTRL, 32'h110);
      repeat (4) @(posedge clk);
      `CHK({oen, on, lat}, 3'b110, "re-enable")
      done("latch");
      // inhibit pin as output: constants, polarity and pwm
      wb(1, `TIP_ADR_CTRL, 32'h08);
      repeat (3) @(posedge clk);
      `CHK({ioe, ipo}, 2'b11, "logic zero level")
      wb(1, `TIP_ADR_CTRL, 32'h48);
      repeat (3) @(posedge clk);
      `CHK(ipo, 1'b0, "logic one level")
      wb(1, `TIP_ADR_CTRL, 32'h68);
      repeat (3) @(posedge clk);
      `CHK(ipo, 1'b1, "inverted logic one")
      wb(1, `TIP_ADR_PWM_PER, 32'h8 + ($urandom % 8));
      wb(1, `TIP_ADR_PWM_HIGH, 32'h3);
      wb(1, `TIP_ADR_CTRL, 32'h88);
      // each full low run (logic one) must last exactly the programmed high count
      n = 0;
      t = 0;
      repeat (64) begin
         @(posedge clk);
         if (ipo !== ipin)
            n = -99;
         if (ipo === 1'b0)
            t++;
         else begin
            if (n > 0 && t != 0 && t != 3)
               n = -99;
            if (t != 0)
               n++;
            t = 0;
         end
      end
      `CHK(n >= 3, 1'b1, "pwm low runs wrong")
      done("inhibit out");
      end_of_test;
   end
endmodule
